// *** pkg/qpsc_pkg.sv ***
`default_nettype none

package qpsc_pkg;

	// ------------------------------------------------------------
	// Instruction opcodes
	// ------------------------------------------------------------
	localparam logic [2:0] OP_NO_OPERATION = 3'h0;
	localparam logic [2:0] OP_ACC_CTRL_RD  = 3'h1;
	localparam logic [2:0] OP_ACC_CTRL_WR  = 3'h3;
	localparam logic [2:0] OP_REG_RD       = 3'h4;
	localparam logic [2:0] OP_REG_WR       = 3'h6;
	localparam logic [2:0] OP_READ_REPLY   = 3'h7;

	// ------------------------------------------------------------
	// Register map and reset values
	// ------------------------------------------------------------
	localparam int unsigned NUM_WIPERS          = 4;
	localparam logic [4:0]  ADDR_WIPER_FIRST    = 5'h00;
	localparam logic [4:0]  ADDR_WIPER_LAST     = 5'h03;
	localparam logic [4:0]  ADDR_ACCESS_CONTROL = 5'h10;
	localparam logic [7:0]  WIPER_RESET         = 8'h80;
	localparam logic [7:0]  ACC_CTRL_RESET      = 8'h40;
	localparam logic [7:0]  ACC_CTRL_WR_MASK    = 8'h42;
	localparam int unsigned ACC_SHUTDOWN_N_BIT  = 6;
	localparam int unsigned ACC_OPEN_DRAIN_BIT  = 1;
	localparam logic [7:0]  UNMAPPED_READ       = 8'h00;

	// ------------------------------------------------------------
	// Link framing and buffering
	// ------------------------------------------------------------
	localparam int unsigned PAIR_BITS   = 16;
	localparam int unsigned BIT_CNT_W   = 4;
	localparam logic [3:0]  BIT_CNT_END = 4'hf;
	localparam int unsigned FIFO_DEPTH  = 32;

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic [2:0] opcode;
		logic [4:0] addr;
	} qpsc_instr_s;

	typedef struct packed {
		qpsc_instr_s instr;
		logic [7:0]  data;
	} qpsc_cmd_s;

	typedef struct packed {
		qpsc_cmd_s shift;
		logic      pair_done;
	} qpsc_link_s;

	typedef struct packed {
		logic [NUM_WIPERS-1:0][7:0] wiper;
		logic [7:0]                 acc_ctrl;
		logic                       cs_idle_prev;
		logic                       cap_pend;
		qpsc_cmd_s                  cap_cmd;
		logic                       oe;
	} qpsc_core_s;

endpackage

`default_nettype wire

// *** logic/qpsc_sync.sv ***
`default_nettype none

module qpsc_sync #(
	parameter int unsigned        WIDTH     = 1,
	parameter logic [WIDTH-1:0]   RESET_VAL = '0
) (
	// Clock and reset
	input  wire logic             clk_in,
	input  wire logic             rst_in,
	// Data
	input  wire logic [WIDTH-1:0] d_in,
	output logic      [WIDTH-1:0] q_out
);

	// ------------------------------------------------------------
	// Two-stage synchroniser
	// ------------------------------------------------------------
	logic [1:0][WIDTH-1:0] stage_reg;
	logic [1:0][WIDTH-1:0] stage_next;

	always_comb begin
		stage_next    = stage_reg;
		stage_next[0] = d_in;
		stage_next[1] = stage_reg[0];
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			stage_reg <= {2{RESET_VAL}};
		end else begin
			stage_reg <= stage_next;
		end
	end

	assign q_out = stage_reg[1];

endmodule

`default_nettype wire

// *** logic/qpsc_fifo.sv ***
`default_nettype none

module qpsc_fifo #(
	parameter int unsigned WIDTH = 16,
	parameter int unsigned DEPTH = 32
) (
	// Clock and reset
	input  wire logic             clk_in,
	input  wire logic             rst_in,
	// Fill side
	input  wire logic             push_valid_in,
	output logic                  push_ready_out,
	input  wire logic [WIDTH-1:0] push_data_in,
	// Drain side
	output logic                  pop_valid_out,
	input  wire logic             pop_ready_in,
	output logic      [WIDTH-1:0] pop_data_out
);

	localparam int unsigned PTR_W = $clog2(DEPTH);

	typedef struct packed {
		logic [PTR_W-1:0] wr_ptr;
		logic [PTR_W-1:0] rd_ptr;
		logic [PTR_W:0]   count;
		logic [WIDTH-1:0] rd_data;
	} qpsc_fifo_s;

	qpsc_fifo_s           s_reg;
	qpsc_fifo_s           s_next;
	logic [WIDTH-1:0]     mem_reg [DEPTH];
	logic                 do_push;
	logic                 do_pop;

	assign push_ready_out = (s_reg.count != (PTR_W+1)'(DEPTH));
	assign pop_valid_out  = (s_reg.count != '0);
	assign pop_data_out   = s_reg.rd_data;
	assign do_push        = push_valid_in && push_ready_out;
	assign do_pop         = pop_valid_out && pop_ready_in;

	always_comb begin
		s_next = s_reg;
		if (do_push) begin
			s_next.wr_ptr = s_reg.wr_ptr + PTR_W'(1);
		end
		if (do_pop) begin
			s_next.rd_ptr = s_reg.rd_ptr + PTR_W'(1);
		end
		if (do_push && !do_pop) begin
			s_next.count = s_reg.count + (PTR_W+1)'(1);
		end else if (do_pop && !do_push) begin
			s_next.count = s_reg.count - (PTR_W+1)'(1);
		end
		// Registered head word, bypassing the array when written now
		s_next.rd_data = mem_reg[s_next.rd_ptr];
		if (do_push && (s_reg.wr_ptr == s_next.rd_ptr)) begin
			s_next.rd_data = push_data_in;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	always_ff @(posedge clk_in) begin
		if (do_push) begin
			mem_reg[s_reg.wr_ptr] <= push_data_in;
		end
	end

endmodule

`default_nettype wire

// *** logic/qpsc_spi_slave.sv ***
`default_nettype none

// Summary of operation
// - Commands execute only after chip select rises
// - Reply byte then register data shifted out
// - Opcodes select no-op, control or addressed access
// - Addresses 0-3 wipers, 10h access control
// - Wipers writable and readable directly
// - Output carries input sixteen bits later
// - Chained writes: only the last pair executes, on chip select rise
// - Chained reads answer in the following frame
// - Reply bytes carry 111b plus address
// - Sample rising edge, shift falling edge, MSB first
// - Opcode top three bits, address low five
// - Wipers reset to 80h, control to 40h
// - Output released when deselected, open-drain option
module qpsc_spi_slave #(
	parameter int unsigned FIFO_DEPTH = qpsc_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic                                   ref_clk_in,
	input  wire logic                                   rst_in,
	// Serial link
	input  wire logic                                   sck_in,
	input  wire logic                                   cs_n_in,
	input  wire logic                                   serial_in_in,
	output logic                                        serial_out_out,
	output logic                                        serial_out_oe_out,
	// Potentiometer controls
	output logic [qpsc_pkg::NUM_WIPERS-1:0][7:0]        wiper_position_out,
	output logic                                        shutdown_n_out
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	qpsc_pkg::qpsc_core_s                  s_reg;
	qpsc_pkg::qpsc_core_s                  s_next;
	qpsc_pkg::qpsc_link_s                  link_reg;
	qpsc_pkg::qpsc_link_s                  link_next;
	logic [qpsc_pkg::BIT_CNT_W-1:0]        bit_cnt_reg;
	logic [qpsc_pkg::BIT_CNT_W-1:0]        bit_cnt_next;
	logic                                  sdo_reg;
	logic                                  link_arst;
	logic                                  cs_idle;
	logic                                  sdo_sync;
	logic                                  push_ready;
	logic                                  pop_valid;
	logic                                  pop_ready;
	qpsc_pkg::qpsc_cmd_s                   pop_cmd;
	qpsc_pkg::qpsc_cmd_s                   shifted;
	logic                                  pop_fire;

	// Register contents as seen by a read reply
	function automatic logic [7:0] read_value(
		input qpsc_pkg::qpsc_instr_s   instr,
		input qpsc_pkg::qpsc_core_s    st
	);
		logic [7:0] val;
		val = qpsc_pkg::UNMAPPED_READ;
		if (instr.opcode == qpsc_pkg::OP_ACC_CTRL_RD) begin
			val = st.acc_ctrl;
		end else if (instr.addr <= qpsc_pkg::ADDR_WIPER_LAST) begin
			val = st.wiper[instr.addr[1:0]];
		end else if (instr.addr == qpsc_pkg::ADDR_ACCESS_CONTROL) begin
			val = st.acc_ctrl;
		end
		return val;
	endfunction

	function automatic logic is_read(input logic [2:0] opcode);
		return (opcode == qpsc_pkg::OP_ACC_CTRL_RD) || (opcode == qpsc_pkg::OP_REG_RD);
	endfunction

	// ------------------------------------------------------------
	// Link domain: bit sampling on rising serial clock
	// ------------------------------------------------------------
	// Frame counter restarts whenever chip select is high
	assign link_arst = rst_in | cs_n_in;
	assign shifted   = {link_reg.shift[qpsc_pkg::PAIR_BITS-2:0], serial_in_in};

	always_comb begin
		link_next           = link_reg;
		bit_cnt_next        = bit_cnt_reg + qpsc_pkg::BIT_CNT_W'(1);
		link_next.shift     = shifted;
		link_next.pair_done = (bit_cnt_reg == qpsc_pkg::BIT_CNT_END);
		// Completed read pair is replaced by its reply
		if ((bit_cnt_reg == qpsc_pkg::BIT_CNT_END) && is_read(shifted.instr.opcode)) begin
			link_next.shift.instr.opcode = qpsc_pkg::OP_READ_REPLY;
			link_next.shift.instr.addr   = shifted.instr.addr;
			link_next.shift.data         = read_value(shifted.instr, s_reg);
		end
	end

	// Shift register survives deselect so a chained reply waits for the next frame
	always_ff @(posedge sck_in or posedge rst_in) begin
		if (rst_in) begin
			link_reg <= '0;
		end else begin
			link_reg <= link_next;
		end
	end

	always_ff @(posedge sck_in or posedge link_arst) begin
		if (link_arst) begin
			bit_cnt_reg <= '0;
		end else begin
			bit_cnt_reg <= bit_cnt_next;
		end
	end

	// Output bit changes on falling serial clock
	always_ff @(negedge sck_in or posedge rst_in) begin
		if (rst_in) begin
			sdo_reg <= 1'b0;
		end else begin
			sdo_reg <= link_reg.shift[qpsc_pkg::PAIR_BITS-1];
		end
	end

	assign serial_out_out = sdo_reg;

	// ------------------------------------------------------------
	// Crossings into the core clock
	// ------------------------------------------------------------
	qpsc_sync #(
		.WIDTH     (2),
		.RESET_VAL (2'h3)
	) u_sync (
		.clk_in (ref_clk_in),
		.rst_in (rst_in),
		.d_in   ({cs_n_in, sdo_reg}),
		.q_out  ({cs_idle, sdo_sync})
	);

	// ------------------------------------------------------------
	// Command buffer
	// ------------------------------------------------------------
	// Registers change only between frames, keeping reply data stable
	assign pop_ready = cs_idle;
	assign pop_fire  = pop_valid && pop_ready;

	qpsc_fifo #(
		.WIDTH (qpsc_pkg::PAIR_BITS),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_in         (ref_clk_in),
		.rst_in         (rst_in),
		.push_valid_in  (s_reg.cap_pend),
		.push_ready_out (push_ready),
		.push_data_in   (s_reg.cap_cmd),
		.pop_valid_out  (pop_valid),
		.pop_ready_in   (pop_ready),
		.pop_data_out   (pop_cmd)
	);

	// ------------------------------------------------------------
	// Core domain: capture, execute, output enable
	// ------------------------------------------------------------
	always_comb begin
		s_next              = s_reg;
		s_next.cs_idle_prev = cs_idle;
		// Released while deselected, open-drain drives only zeros
		s_next.oe = !cs_idle &&
			(!s_reg.acc_ctrl[qpsc_pkg::ACC_OPEN_DRAIN_BIT] || !sdo_sync);
		if (s_reg.cap_pend && push_ready) begin
			s_next.cap_pend = 1'b0;
		end
		// Closing pair is taken on chip select rise, only when the frame ends on a pair boundary
		if (cs_idle && !s_reg.cs_idle_prev && link_reg.pair_done) begin
			s_next.cap_pend = 1'b1;
			s_next.cap_cmd  = link_reg.shift;
		end
		if (pop_fire) begin
			case (pop_cmd.instr.opcode)
				qpsc_pkg::OP_ACC_CTRL_WR: begin
					s_next.acc_ctrl = pop_cmd.data & qpsc_pkg::ACC_CTRL_WR_MASK;
				end
				qpsc_pkg::OP_REG_WR: begin
					if (pop_cmd.instr.addr <= qpsc_pkg::ADDR_WIPER_LAST) begin
						s_next.wiper[pop_cmd.instr.addr[1:0]] = pop_cmd.data;
					end else if (pop_cmd.instr.addr == qpsc_pkg::ADDR_ACCESS_CONTROL) begin
						s_next.acc_ctrl = pop_cmd.data & qpsc_pkg::ACC_CTRL_WR_MASK;
					end
				end
				default: begin
					s_next.acc_ctrl = s_reg.acc_ctrl;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			s_reg              <= '0;
			s_reg.wiper        <= {qpsc_pkg::NUM_WIPERS{qpsc_pkg::WIPER_RESET}};
			s_reg.acc_ctrl     <= qpsc_pkg::ACC_CTRL_RESET;
			s_reg.cs_idle_prev <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	assign wiper_position_out = s_reg.wiper;
	assign shutdown_n_out     = s_reg.acc_ctrl[qpsc_pkg::ACC_SHUTDOWN_N_BIT];
	assign serial_out_oe_out  = s_reg.oe;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	a_reset_values: assert property (@(posedge ref_clk_in)
		$fell(rst_in) |-> (s_reg.acc_ctrl == qpsc_pkg::ACC_CTRL_RESET) &&
		(s_reg.wiper == {qpsc_pkg::NUM_WIPERS{qpsc_pkg::WIPER_RESET}}))
		else $error("Registers not at reset values");

	a_no_exec_in_frame: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		!cs_idle |=> $stable(s_reg.wiper) && $stable(s_reg.acc_ctrl))
		else $error("Register changed while chip select low");

	a_wiper_write: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		pop_fire && (pop_cmd.instr.opcode == qpsc_pkg::OP_REG_WR) &&
		(pop_cmd.instr.addr <= qpsc_pkg::ADDR_WIPER_LAST)
		|=> s_reg.wiper[$past(pop_cmd.instr.addr[1:0])] == $past(pop_cmd.data))
		else $error("Wiper write not applied");

	a_ctrl_write: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		pop_fire && (pop_cmd.instr.opcode == qpsc_pkg::OP_ACC_CTRL_WR)
		|=> s_reg.acc_ctrl == ($past(pop_cmd.data) & qpsc_pkg::ACC_CTRL_WR_MASK))
		else $error("Access control write not applied");

	a_ctrl_by_address: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		pop_fire && (pop_cmd.instr.opcode == qpsc_pkg::OP_REG_WR) &&
		(pop_cmd.instr.addr == qpsc_pkg::ADDR_ACCESS_CONTROL)
		|=> s_reg.acc_ctrl == ($past(pop_cmd.data) & qpsc_pkg::ACC_CTRL_WR_MASK))
		else $error("Addressed control write not applied");

	a_ctrl_fixed_bits: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(s_reg.acc_ctrl & ~qpsc_pkg::ACC_CTRL_WR_MASK) == 8'h00)
		else $error("Read-only control bit set");

	a_unknown_ignored: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		pop_fire && (pop_cmd.instr.opcode != qpsc_pkg::OP_ACC_CTRL_WR) &&
		!((pop_cmd.instr.opcode == qpsc_pkg::OP_REG_WR) &&
		((pop_cmd.instr.addr <= qpsc_pkg::ADDR_WIPER_LAST) ||
		(pop_cmd.instr.addr == qpsc_pkg::ADDR_ACCESS_CONTROL)))
		|=> $stable(s_reg.wiper) && $stable(s_reg.acc_ctrl))
		else $error("Ignored command changed a register");

	// Output enable
	a_oe_released: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		cs_idle [*2] |-> !serial_out_oe_out)
		else $error("Serial output driven while deselected");

	a_oe_push_pull: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		!cs_idle && !s_reg.acc_ctrl[qpsc_pkg::ACC_OPEN_DRAIN_BIT] |=> serial_out_oe_out)
		else $error("Push-pull output not driven in frame");

	a_oe_open_drain: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		s_reg.acc_ctrl[qpsc_pkg::ACC_OPEN_DRAIN_BIT] && sdo_sync
		|=> !serial_out_oe_out)
		else $error("Open-drain output drove a one");

	a_oe_drain_zero: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		!cs_idle && s_reg.acc_ctrl[qpsc_pkg::ACC_OPEN_DRAIN_BIT] && !sdo_sync
		|=> serial_out_oe_out)
		else $error("Open-drain output did not pull low");

	// Capture and buffer
	a_capture_queued: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		cs_idle && !s_reg.cs_idle_prev && link_reg.pair_done
		|=> s_reg.cap_pend && (s_reg.cap_cmd == $past(link_reg.shift)))
		else $error("Closing pair not captured");

	a_capture_pushed: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		s_reg.cap_pend && push_ready && !(cs_idle && !s_reg.cs_idle_prev)
		|=> !s_reg.cap_pend)
		else $error("Captured pair not handed to buffer");

	a_no_lost_command: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		s_reg.cap_pend |-> push_ready)
		else $error("Closing pair dropped by full buffer");

	a_read_reply: assert property (@(posedge sck_in) disable iff (link_arst)
		(bit_cnt_reg == qpsc_pkg::BIT_CNT_END) && is_read(shifted.instr.opcode)
		|=> (link_reg.shift.instr.opcode == qpsc_pkg::OP_READ_REPLY) &&
		(link_reg.shift.instr.addr == $past(shifted.instr.addr)))
		else $error("Read pair not replaced by reply");

	// Read replies against register state
	a_reply_wiper: assert property (@(posedge sck_in) disable iff (link_arst)
		(bit_cnt_reg == qpsc_pkg::BIT_CNT_END) &&
		(shifted.instr.opcode == qpsc_pkg::OP_REG_RD) &&
		(shifted.instr.addr <= qpsc_pkg::ADDR_WIPER_LAST)
		|=> link_reg.shift.data == $past(s_reg.wiper[shifted.instr.addr[1:0]]))
		else $error("Read reply data not the wiper value");

	a_reply_ctrl: assert property (@(posedge sck_in) disable iff (link_arst)
		(bit_cnt_reg == qpsc_pkg::BIT_CNT_END) &&
		(shifted.instr.opcode == qpsc_pkg::OP_ACC_CTRL_RD)
		|=> link_reg.shift.data == $past(s_reg.acc_ctrl))
		else $error("Read reply data not the control value");

	a_unmapped_reply: assert property (@(posedge sck_in) disable iff (link_arst)
		(bit_cnt_reg == qpsc_pkg::BIT_CNT_END) &&
		(shifted.instr.opcode == qpsc_pkg::OP_REG_RD) &&
		(shifted.instr.addr > qpsc_pkg::ADDR_WIPER_LAST) &&
		(shifted.instr.addr != qpsc_pkg::ADDR_ACCESS_CONTROL)
		|=> link_reg.shift.data == qpsc_pkg::UNMAPPED_READ)
		else $error("Unmapped read reply not zero");

	a_pass_through: assert property (@(posedge sck_in) disable iff (link_arst)
		!((bit_cnt_reg == qpsc_pkg::BIT_CNT_END) && is_read(shifted.instr.opcode))
		|=> link_reg.shift[0] == $past(serial_in_in))
		else $error("Input bit not shifted in");

	a_pair_boundary: assert property (@(posedge sck_in) disable iff (link_arst)
		!cs_n_in |=> link_reg.pair_done == ($past(bit_cnt_reg) == qpsc_pkg::BIT_CNT_END))
		else $error("Pair boundary flag misplaced");

	a_sdo_shift_out: assert property (@(negedge sck_in) disable iff (link_arst)
		!cs_n_in
		|=> serial_out_out == $past(link_reg.shift[qpsc_pkg::PAIR_BITS-1]))
		else $error("Serial output not taken from shift register");

	c_wiper_write: cover property (@(posedge ref_clk_in) disable iff (rst_in)
		pop_fire && (pop_cmd.instr.opcode == qpsc_pkg::OP_REG_WR));

	c_read_reply: cover property (@(posedge sck_in) disable iff (link_arst)
		(bit_cnt_reg == qpsc_pkg::BIT_CNT_END) && is_read(shifted.instr.opcode));

	c_fifo_full: cover property (@(posedge ref_clk_in) disable iff (rst_in)
		s_reg.cap_pend && !push_ready);

	c_open_drain: cover property (@(posedge ref_clk_in) disable iff (rst_in)
		!cs_idle && s_reg.acc_ctrl[qpsc_pkg::ACC_OPEN_DRAIN_BIT]);

	c_ctrl_write: cover property (@(posedge ref_clk_in) disable iff (rst_in)
		pop_fire && (pop_cmd.instr.opcode == qpsc_pkg::OP_ACC_CTRL_WR));

endmodule

`default_nettype wire

// *** tb/qpsc_host_model.sv ***
`default_nettype none

module qpsc_host_model (
	// Serial link
	output logic     sck_out,
	output logic     cs_n_out,
	output logic     serial_in_out,
	input  wire logic serial_out_in
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		sck_out       = 1'b0;
		cs_n_out      = 1'b1;
		serial_in_out = 1'b0;
	end

	// ----------------------------------------
	// Frame open and shift, 64 ns link period
	// ----------------------------------------
	task automatic shift(input logic [31:0] tx, input int nbits, output logic [31:0] rx);
		int i;
		rx       = '0;
		cs_n_out = 1'b0;
		#32;
		for (i = nbits - 1; i >= 0; i--) begin
			serial_in_out = tx[i];
			#32 sck_out = 1'b1;
			rx = {rx[30:0], serial_out_in};
			#32 sck_out = 1'b0;
		end
		serial_in_out = ~serial_in_out;
	endtask

	// ----------------------------------------
	// Frame close, then idle time for execution
	// ----------------------------------------
	task automatic close();
		#16 cs_n_out = 1'b1;
		#80;
	endtask
endmodule

`default_nettype wire

// *** tb/quad_pot_spi_command_slave_tb_top.sv ***
`default_nettype none

module quad_pot_spi_command_slave_tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	logic                  ref_clk = 1'b0;
	logic                  rst     = 1'b1;
	logic                  sck;
	logic                  cs_n;
	logic                  serial_in;
	logic                  serial_out;
	logic                  sdo_oe;
	logic                  line;
	logic [3:0][7:0]       wipers;
	logic                  shutdown_n;
	logic [31:0]           rx;
	logic [7:0]            v;
	int                    mismatches      = 0;
	int                    samples_checked = 0;
	int                    cycles          = 0;
	int                    i;
	logic [2:0]            bad_ops [4] = '{3'h0, 3'h2, 3'h5, 3'h7};

	always #2.5 ref_clk = ~ref_clk;

	// Pull-up on the shared output line
	assign line = sdo_oe ? serial_out : 1'b1;

	qpsc_spi_slave #(.FIFO_DEPTH(32)) u_dut (
		.ref_clk_in         (ref_clk),
		.rst_in             (rst),
		.sck_in             (sck),
		.cs_n_in            (cs_n),
		.serial_in_in       (serial_in),
		.serial_out_out     (serial_out),
		.serial_out_oe_out  (sdo_oe),
		.wiper_position_out (wipers),
		.shutdown_n_out     (shutdown_n)
	);

	qpsc_host_model u_host (
		.sck_out       (sck),
		.cs_n_out      (cs_n),
		.serial_in_out (serial_in),
		.serial_out_in (line)
	);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic wr(input logic [7:0] ins, input logic [7:0] d);
		u_host.shift({16'h0000, ins, d}, 16, rx);
		u_host.close();
	endtask

	// Four-byte read: instruction, dummy, no-op, dummy
	task automatic rd(input logic [7:0] ins, output logic [7:0] d);
		u_host.shift({ins, 24'h000000}, 32, rx);
		u_host.close();
		check(rx[15:8], {qpsc_pkg::OP_READ_REPLY, ins[4:0]});
		d = rx[7:0];
	endtask

	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 40000) begin
			mismatches++;
			conclude();
		end
	end

	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		repeat (16) @(posedge ref_clk);
		@(negedge ref_clk) rst = 1'b0;
		repeat (3) @(negedge ref_clk);

		for (i = 0; i < 4; i++)
			check(wipers[i], qpsc_pkg::WIPER_RESET);
		check(shutdown_n, 1'b1);
		check(sdo_oe, 1'b0);
		rd({qpsc_pkg::OP_ACC_CTRL_RD, 5'h10}, v);
		check(v, qpsc_pkg::ACC_CTRL_RESET);
		$display("test reset_values done");

		for (i = 0; i < 4; i++) begin
			u_host.shift({16'h0000, qpsc_pkg::OP_REG_WR, 5'(i), 8'h5a + 8'(i * 37)}, 16, rx);
			check(wipers[i], qpsc_pkg::WIPER_RESET);
			u_host.close();
			check(wipers[i], 8'h5a + 8'(i * 37));
			rd({qpsc_pkg::OP_REG_RD, 5'(i)}, v);
			check(v, 8'h5a + 8'(i * 37));
		end
		$display("test wiper_access done");

		wr({qpsc_pkg::OP_ACC_CTRL_WR, 5'h05}, 8'hbd);
		check(shutdown_n, 1'b0);
		wr({qpsc_pkg::OP_ACC_CTRL_WR, 5'h10}, 8'hff);
		check(shutdown_n, 1'b1);
		rd({qpsc_pkg::OP_ACC_CTRL_RD, 5'h10}, v);
		check(v, qpsc_pkg::ACC_CTRL_WR_MASK);
		rd({qpsc_pkg::OP_REG_RD, 5'h03}, v);
		check(v, 8'h5a + 8'(3 * 37));
		check(sdo_oe, 1'b0);
		wr({qpsc_pkg::OP_ACC_CTRL_WR, 5'h10}, qpsc_pkg::ACC_CTRL_RESET);
		$display("test access_control done");

		for (i = 0; i < 4; i++) begin
			wr({bad_ops[i], 5'h00}, 8'h00);
			check(wipers[0], 8'h5a);
		end
		wr({qpsc_pkg::OP_REG_WR, 5'h05}, 8'h00);
		check(shutdown_n, 1'b1);
		rd({qpsc_pkg::OP_REG_RD, 5'h05}, v);
		check(v, qpsc_pkg::UNMAPPED_READ);
		$display("test refused_ops done");

		u_host.shift({qpsc_pkg::OP_REG_WR, 5'h01, 8'ha5, qpsc_pkg::OP_REG_WR, 5'h02, 8'h3c},
			32, rx);
		u_host.close();
		check(rx[15:0], {qpsc_pkg::OP_REG_WR, 5'h01, 8'ha5});
		check(wipers[1], 8'h5a + 8'd37);
		check(wipers[2], 8'h3c);
		u_host.shift({16'h0000, qpsc_pkg::OP_REG_RD, 5'h02, 8'h00}, 16, rx);
		u_host.close();
		u_host.shift(32'h00000000, 16, rx);
		u_host.close();
		check(rx[15:0], {qpsc_pkg::OP_READ_REPLY, 5'h02, 8'h3c});
		$display("test chain done");

		conclude();
	end
endmodule

`default_nettype wire
